// >>> include/usbrx_pkg.sv
// Purpose: Shared constants for the receive endpoint control/status block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: Register indices are word indices; byte address is index * 4
package usbrx_pkg;
	// ==========================================================
	// Bus geometry
	localparam int USBRX_ADR_W = 12;
	localparam int USBRX_IDX_W = 10;
	localparam int USBRX_LEN_W = 11;
	// ==========================================================
	// Register indices
	localparam logic [9:0] USBRX_IDX_LOW1 = 10'h116;
	localparam logic [9:0] USBRX_IDX_HIGH1 = 10'h117;
	localparam logic [9:0] USBRX_IDX_HIGH2 = 10'h127;
	localparam logic [9:0] USBRX_IDX_HIGH3 = 10'h137;
	localparam logic [9:0] USBRX_IDX_CFG = 10'h140;
	localparam logic [9:0] USBRX_IDX_STAT = 10'h141;
	// ==========================================================
	// Low control/status field positions
	localparam int USBRX_LO_TOGGLE_RESET = 7;
	localparam int USBRX_LO_STALLED = 6;
	localparam int USBRX_LO_SEND_STALL = 5;
	localparam int USBRX_LO_FLUSH = 4;
	localparam int USBRX_LO_DATA_ERROR = 3;
	localparam int USBRX_LO_OVERRUN = 2;
	localparam int USBRX_LO_FULL = 1;
	localparam int USBRX_LO_READY = 0;
	// High control/status field positions
	localparam int USBRX_HI_AUTO_CLEAR = 7;
	// ==========================================================
	// Configuration word fields
	localparam int USBRX_CFG_MAXP_LSB = 0;
	localparam int USBRX_CFG_ISO = 16;
	localparam int USBRX_CFG_HOST = 17;
	localparam int USBRX_CFG_DMA = 18;
	// Status word fields
	localparam int USBRX_ST_TOGGLE = 0;
	localparam int USBRX_ST_STALL_OUT = 1;
	localparam int USBRX_ST_COUNT_LSB = 8;
	// ==========================================================
	// Values after reset
	localparam logic [7:0] USBRX_LOW_RST = 8'h00;
	localparam logic [7:0] USBRX_HIGH_RST = 8'h00;
	localparam logic [10:0] USBRX_MAXP_RST = 11'h040;
	// DMA unload granule in bytes
	localparam logic [2:0] USBRX_DMA_CHUNK = 3'h4;
endpackage

// >>> hdl/usbrx_pkt_queue.sv
// Purpose: Packet bookkeeping for the receive FIFO (length and error)
// Assumes: Push and pop are single-cycle pulses on clk_i
// Notes: A push while full is dropped; the caller flags the overrun
`timescale 1ns/10ps
module usbrx_pkt_queue
	import usbrx_pkg::*;
#(
	parameter int DEPTH = 2,
	parameter int LEN_W = USBRX_LEN_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic [LEN_W-1:0] push_len_i,
	input wire logic push_err_i,
	input wire logic pop_i,
	output logic [$clog2(DEPTH+1)-1:0] count_o,
	output logic full_o,
	output logic [LEN_W-1:0] head_len_o,
	output logic head_err_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 1 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
		$error("DEPTH must be a power of two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][LEN_W:0] ent;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
	} usbrx_q_t;

	usbrx_q_t q, next_q;
	logic do_push, do_pop;

	// ==========================================================
	// Pointer and count update; full drops the push
	always_comb begin
		next_q = q;
		do_push = push_i && (q.cnt != CW'(DEPTH));
		do_pop = pop_i && (q.cnt != '0);
		if (do_push) begin
			next_q.ent[q.wr] = {push_err_i, push_len_i};
			// A single slot keeps its pointer at zero
			next_q.wr = (DEPTH > 1) ? q.wr + PW'(1) : PW'(0);
		end
		if (do_pop)
			next_q.rd = (DEPTH > 1) ? q.rd + PW'(1) : PW'(0);
		if (do_push && !do_pop)
			next_q.cnt = q.cnt + CW'(1);
		else if (do_pop && !do_push)
			next_q.cnt = q.cnt - CW'(1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			q <= '0;
		else
			q <= next_q;
	end

	assign count_o = q.cnt;
	assign full_o = (q.cnt == CW'(DEPTH));
	assign head_len_o = q.ent[q.rd][LEN_W-1:0];
	assign head_err_o = q.ent[q.rd][LEN_W];

	// ==========================================================
	// Checks
	count_bound_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		push_i && full_o && !pop_i |=> full_o && $stable(q.wr))
		else $error("push while full altered the queue");
endmodule // usbrx_pkt_queue

// >>> hdl/usbrx_auto_clear.sv
// Purpose: Decides when an unload completes a packet for auto-clear
// Assumes: total_i is the byte count unloaded including the current read
// Notes: Pure combinational decision, registered by the caller
`timescale 1ns/10ps
module usbrx_auto_clear
	import usbrx_pkg::*;
#(
	parameter int LEN_W = USBRX_LEN_W
) (
	input wire logic [LEN_W-1:0] maxp_i,
	input wire logic [LEN_W-1:0] len_i,
	input wire logic [LEN_W:0] total_i,
	input wire logic dma_i,
	output logic hit_o
);
	logic [1:0] rem;
	logic [LEN_W:0] span;
	logic [LEN_W:0] round_up;
	logic [LEN_W:0] low_len;

	// ==========================================================
	// DMA reads whole chunks, so the last read overshoots short sizes
	always_comb begin
		rem = maxp_i[1:0];
		span = (rem == 2'h0) ? (LEN_W+1)'(USBRX_DMA_CHUNK)
			: (LEN_W+1)'(rem);
		round_up = {1'b0, maxp_i} + ((LEN_W+1)'(USBRX_DMA_CHUNK)
			- (LEN_W+1)'(rem)) % (LEN_W+1)'(USBRX_DMA_CHUNK);
		low_len = {1'b0, len_i} + span;
		if (dma_i) begin
			// Sizes in (max - span, max] complete on the rounded count
			hit_o = (len_i <= maxp_i) && (low_len > {1'b0, maxp_i})
				&& (total_i >= round_up);
		end else begin
			// Only a full-size packet clears itself
			hit_o = (len_i == maxp_i) && (total_i >= {1'b0, maxp_i});
		end
	end
endmodule // usbrx_auto_clear

// >>> hdl/usbrx_endpoint.sv
// Purpose: CPU-side control and status of one USB receive endpoint
// Assumes: USB-side events are one-cycle pulses from logic on clk_i
// Notes: Registers are reached over classic Wishbone, 32-bit words
//
// Operation
// - Writing one to toggle-reset forces the data toggle to zero.
// - Stalled flag sets when a STALL is sent, stays until CPU clears.
// - While send-stall is one the endpoint answers with STALL.
// - Send-stall has no effect when the endpoint is isochronous.
// - Flush discards the next packet, resets pointer, clears ready unless another is queued.
// - Data-error sets with ready on CRC/stuff error, clears with it.
// - Data-error and overrun read zero outside isochronous mode.
// - Overrun sets when an OUT packet cannot be stored, CPU clears.
// - FIFO-full is set whenever no further packet fits.
// - Packet received sets ready and signals; CPU clears after unload.
// - Host role auto-clear clears ready after a max-size unload.
// - DMA unloads in four-byte units; remainder zero clears sizes max-3 to max.
// - Each endpoint has an 8-bit high control and status register.
// - DMA clear sizes follow the max size remainder modulo four.
`timescale 1ns/10ps
module usbrx_endpoint
	import usbrx_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [USBRX_ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic pkt_rcvd_i,
	input wire logic [USBRX_LEN_W-1:0] pkt_len_i,
	input wire logic pkt_err_i,
	input wire logic stall_sent_i,
	input wire logic fifo_rd_i,
	input wire logic [2:0] fifo_rd_bytes_i,
	output logic stall_o,
	output logic data_toggle_o,
	output logic ready_event_o,
	output logic fifo_ptr_reset_o,
	output logic packet_ready_o,
	output logic fifo_full_o
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int LW = USBRX_LEN_W;

	if (DEPTH < 1 || DEPTH > 8) begin : g_depth_bad
		$error("DEPTH outside 1..8");
	end

	// ==========================================================
	// State
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic stalled;
		logic send_stall;
		logic overrun;
		logic toggle;
		logic cfg_iso;
		logic cfg_host;
		logic cfg_dma;
		logic [LW-1:0] maxp;
		logic auto_clear;
		logic [6:0] high1_rest;
		logic [7:0] high2;
		logic [7:0] high3;
		logic [LW:0] unloaded;
		logic evt;
		logic ptr_rst;
		logic stall_out;
		logic ready_out;
		logic full_out;
	} usbrx_state_t;

	usbrx_state_t s, next_s;

	// Queue and decision wires
	logic [CW-1:0] q_count;
	logic q_full;
	logic [LW-1:0] head_len;
	logic head_err;
	logic ready;
	logic [LW:0] total;
	logic hit;
	logic pop;
	logic push_ok;
	logic auto_fire;

	// Bus decode wires
	logic [USBRX_IDX_W-1:0] idx;
	logic req;
	logic wr;
	logic wr_low;
	logic wr_high1;
	logic flush_req;
	logic cpu_clear_ready;
	logic [7:0] rd_low;
	logic [31:0] rd_word;

	// ==========================================================
	// Packet bookkeeping
	usbrx_pkt_queue #(
		.DEPTH(DEPTH),
		.LEN_W(LW)
	) u_queue (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(pkt_rcvd_i),
		.push_len_i(pkt_len_i),
		.push_err_i(pkt_err_i),
		.pop_i(pop),
		.count_o(q_count),
		.full_o(q_full),
		.head_len_o(head_len),
		.head_err_o(head_err)
	);

	// Auto-clear decision on the byte count after this read
	usbrx_auto_clear #(
		.LEN_W(LW)
	) u_auto (
		.maxp_i(s.maxp),
		.len_i(head_len),
		.total_i(total),
		.dma_i(s.cfg_dma),
		.hit_o(hit)
	);

	// ==========================================================
	// Bus decode; writes land on the edge that sees ack high
	always_comb begin
		idx = adr_i[USBRX_ADR_W-1:2];
		req = cyc_i && stb_i;
		wr = req && we_i && s.ack;
		wr_low = wr && sel_i[0] && (idx == USBRX_IDX_LOW1);
		wr_high1 = wr && sel_i[0] && (idx == USBRX_IDX_HIGH1);
	end

	// ==========================================================
	// Packet-ready and unload tracking
	always_comb begin
		ready = (q_count != '0);
		push_ok = pkt_rcvd_i && !q_full;
		total = s.unloaded + (LW+1)'(fifo_rd_bytes_i);
		flush_req = wr_low && dat_i[USBRX_LO_FLUSH];
		// Only a written zero clears; a one leaves ready alone
		cpu_clear_ready = wr_low && !dat_i[USBRX_LO_READY];
		auto_fire = s.cfg_host && s.auto_clear && ready && fifo_rd_i
			&& hit;
		pop = ready && (flush_req || cpu_clear_ready || auto_fire);
	end

	// ==========================================================
	// Read value of the low register
	always_comb begin
		rd_low = USBRX_LOW_RST;
		rd_low[USBRX_LO_STALLED] = s.stalled;
		rd_low[USBRX_LO_SEND_STALL] = s.send_stall;
		// Error flags only mean something for isochronous traffic
		rd_low[USBRX_LO_DATA_ERROR] = s.cfg_iso && ready
			&& head_err;
		rd_low[USBRX_LO_OVERRUN] = s.cfg_iso && s.overrun;
		rd_low[USBRX_LO_FULL] = q_full;
		rd_low[USBRX_LO_READY] = ready;
	end

	// ==========================================================
	// Read word mux; unmapped words answer zero
	always_comb begin
		rd_word = '0;
		case (idx)
			USBRX_IDX_LOW1: begin
				rd_word[7:0] = rd_low;
			end
			USBRX_IDX_HIGH1: begin
				rd_word[7:0] = {s.auto_clear, s.high1_rest};
			end
			USBRX_IDX_HIGH2: begin
				rd_word[7:0] = s.high2;
			end
			USBRX_IDX_HIGH3: begin
				rd_word[7:0] = s.high3;
			end
			USBRX_IDX_CFG: begin
				rd_word[USBRX_CFG_MAXP_LSB +: LW] = s.maxp;
				rd_word[USBRX_CFG_ISO] = s.cfg_iso;
				rd_word[USBRX_CFG_HOST] = s.cfg_host;
				rd_word[USBRX_CFG_DMA] = s.cfg_dma;
			end
			USBRX_IDX_STAT: begin
				rd_word[USBRX_ST_TOGGLE] = s.toggle;
				rd_word[USBRX_ST_STALL_OUT] = s.stall_out;
				rd_word[USBRX_ST_COUNT_LSB +: CW] = q_count;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		// One wait state: ack rises a cycle after the request, then drops
		next_s.ack = req && !s.ack;
		if (req && !s.ack)
			next_s.rdata = rd_word;

		// Hardware set beats a same-cycle software clear
		if (wr_low && !dat_i[USBRX_LO_STALLED])
			next_s.stalled = 1'b0;
		if (stall_sent_i)
			next_s.stalled = 1'b1;

		if (wr_low)
			next_s.send_stall = dat_i[USBRX_LO_SEND_STALL];

		if (wr_low && !dat_i[USBRX_LO_OVERRUN])
			next_s.overrun = 1'b0;
		if (pkt_rcvd_i && q_full)
			next_s.overrun = 1'b1;

		// Each stored packet advances the toggle; a reset request wins
		if (push_ok)
			next_s.toggle = !s.toggle;
		if (wr_low && dat_i[USBRX_LO_TOGGLE_RESET])
			next_s.toggle = 1'b0;

		if (wr_high1) begin
			next_s.auto_clear = dat_i[USBRX_HI_AUTO_CLEAR];
			next_s.high1_rest = dat_i[6:0];
		end
		if (wr && sel_i[0] && idx == USBRX_IDX_HIGH2)
			next_s.high2 = dat_i[7:0];
		if (wr && sel_i[0] && idx == USBRX_IDX_HIGH3)
			next_s.high3 = dat_i[7:0];
		if (wr && idx == USBRX_IDX_CFG) begin
			if (sel_i[0])
				next_s.maxp[7:0] = dat_i[7:0];
			if (sel_i[1])
				next_s.maxp[LW-1:8] = dat_i[LW-1:8];
			if (sel_i[2]) begin
				next_s.cfg_iso = dat_i[USBRX_CFG_ISO];
				next_s.cfg_host = dat_i[USBRX_CFG_HOST];
				next_s.cfg_dma = dat_i[USBRX_CFG_DMA];
			end
		end

		// Byte count of the head packet restarts with each new head
		if (pop)
			next_s.unloaded = '0;
		else if (fifo_rd_i && ready)
			next_s.unloaded = total;

		// Output flops
		next_s.evt = push_ok;
		next_s.ptr_rst = flush_req;
		next_s.stall_out = next_s.send_stall
			&& !next_s.cfg_iso;
		next_s.ready_out = ready;
		next_s.full_out = q_full;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.maxp <= USBRX_MAXP_RST;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign dat_o = s.rdata;
	assign ack_o = s.ack;
	assign stall_o = s.stall_out;
	assign data_toggle_o = s.toggle;
	assign ready_event_o = s.evt;
	assign fifo_ptr_reset_o = s.ptr_rst;
	assign packet_ready_o = s.ready_out;
	assign fifo_full_o = s.full_out;

	// ==========================================================
	// Checks
	ack_single_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	toggle_reset_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_low && dat_i[USBRX_LO_TOGGLE_RESET] |=> !data_toggle_o)
		else $error("toggle not cleared by reset write");

	stalled_set_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		stall_sent_i |=> s.stalled [*1] ##1
		(s.stalled || $past(wr_low && !dat_i[USBRX_LO_STALLED])))
		else $error("stalled flag not set by sent stall");

	stall_issue_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_low && dat_i[USBRX_LO_SEND_STALL] && !s.cfg_iso
		&& !(wr && idx == USBRX_IDX_CFG) |=> stall_o)
		else $error("stall not issued");

	iso_no_stall_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s.cfg_iso |-> !stall_o)
		else $error("stall driven in isochronous mode");

	flush_pop_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		flush_req && ready && !pkt_rcvd_i
		|=> q_count == $past(q_count) - CW'(1) && fifo_ptr_reset_o)
		else $error("flush did not drop a packet");

	bulk_flags_zero_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		req && !s.ack && idx == USBRX_IDX_LOW1 && !s.cfg_iso
		|=> dat_o[USBRX_LO_DATA_ERROR:USBRX_LO_OVERRUN] == 2'h0)
		else $error("error flags visible in bulk mode");

	overrun_set_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		pkt_rcvd_i && q_full |=> s.overrun)
		else $error("overrun not flagged");

	ready_event_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		pkt_rcvd_i && !q_full |=> ready_event_o ##1 packet_ready_o)
		else $error("received packet not signalled");

	auto_clear_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		auto_fire && !pkt_rcvd_i |=> q_count == $past(q_count) - CW'(1))
		else $error("auto-clear did not release packet");

	w0c_no_set_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_low && dat_i[USBRX_LO_STALLED] && !s.stalled && !stall_sent_i
		|=> !s.stalled)
		else $error("writing one set a clear-only flag");
endmodule // usbrx_endpoint

// >>> tb/usbrx_usb_model.sv
// Purpose: USB-side stand-in that feeds packet, stall and unload events
// Assumes: Every event is driven just after a rising edge of clk_i
// Notes: Idle qualifiers show the inverse of their last value
`timescale 1ns/10ps
module usbrx_usb_model (
	input wire logic clk_i,
	input wire logic stall_i,
	output logic pkt_rcvd_o,
	output logic [10:0] pkt_len_o,
	output logic pkt_err_o,
	output logic stall_sent_o,
	output logic fifo_rd_o,
	output logic [2:0] rd_bytes_o
);
	// ==========================================================
	// Idle levels at time zero
	initial begin
		pkt_rcvd_o = 1'b0;
		pkt_len_o = 11'h000;
		pkt_err_o = 1'b0;
		stall_sent_o = 1'b0;
		fifo_rd_o = 1'b0;
		rd_bytes_o = 3'h0;
	end
	// ==========================================================
	// One OUT data packet, qualifiers inverted once it is over
	task send(input logic [10:0] len, input logic err);
		@(posedge clk_i);
		pkt_rcvd_o <= 1'b1;
		pkt_len_o <= len;
		pkt_err_o <= err;
		@(posedge clk_i);
		pkt_rcvd_o <= 1'b0;
		pkt_len_o <= ~len;
		pkt_err_o <= ~err;
	endtask
	// Back-to-back four-byte unload reads, as a DMA engine makes them
	task unload(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			fifo_rd_o <= 1'b1;
			rd_bytes_o <= 3'h4;
		end
		@(posedge clk_i);
		fifo_rd_o <= 1'b0;
		rd_bytes_o <= 3'h3;
	endtask
	// A token arrives; a STALL goes out only if the endpoint asks for it
	task token;
		@(posedge clk_i);
		stall_sent_o <= stall_i;
		@(posedge clk_i);
		stall_sent_o <= 1'b0;
	endtask
endmodule // usbrx_usb_model

// >>> tb/tb_usbrx_endpoint.sv
// Purpose: Register-level checks of the receive endpoint
// Assumes: Classic Wishbone, one wait state, DEPTH of two packets
// Notes: Expected values come from the package constants and literal values
`timescale 1ns/10ps
module tb_usbrx_endpoint
	import usbrx_pkg::*;
;
	localparam logic [31:0] RDY = 32'h1 << USBRX_LO_READY;
	localparam logic [31:0] FUL = 32'h1 << USBRX_LO_FULL;
	localparam logic [31:0] OVR = 32'h1 << USBRX_LO_OVERRUN;
	localparam logic [31:0] ERR = 32'h1 << USBRX_LO_DATA_ERROR;
	localparam logic [31:0] FLS = 32'h1 << USBRX_LO_FLUSH;
	localparam logic [31:0] SST = 32'h1 << USBRX_LO_SEND_STALL;
	localparam logic [31:0] STD = 32'h1 << USBRX_LO_STALLED;
	localparam logic [31:0] TGL = 32'h1 << USBRX_LO_TOGGLE_RESET;
	localparam logic [31:0] ACL = 32'h1 << USBRX_HI_AUTO_CLEAR;
	localparam logic [31:0] HOST = 32'h1 << USBRX_CFG_HOST;
	logic clk_i, rst_i, cyc, stb, we, ack, stall, tgl, evt, ptr, rdy, full;
	logic [USBRX_ADR_W-1:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic rcvd, perr, ssent, frd;
	logic [10:0] plen;
	logic [2:0] rbytes;
	int mismatches, cmp_count, cycles, n_evt, n_ptr;
	bit dm[8] = '{0, 0, 1, 1, 1, 1, 1, 1};
	int mp[8] = '{8, 8, 6, 6, 7, 8, 5, 5};
	int ln[8] = '{8, 5, 5, 4, 5, 5, 5, 4};
	bit cl[8] = '{1, 0, 1, 0, 1, 1, 1, 0};
	usbrx_endpoint u_usbrx_endpoint (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pkt_rcvd_i(rcvd),
		.pkt_len_i(plen), .pkt_err_i(perr), .stall_sent_i(ssent),
		.fifo_rd_i(frd), .fifo_rd_bytes_i(rbytes), .stall_o(stall),
		.data_toggle_o(tgl), .ready_event_o(evt), .fifo_ptr_reset_o(ptr),
		.packet_ready_o(rdy), .fifo_full_o(full));
	usbrx_usb_model u_usbrx_usb_model (.clk_i(clk_i), .stall_i(stall),
		.pkt_rcvd_o(rcvd), .pkt_len_o(plen), .pkt_err_o(perr),
		.stall_sent_o(ssent), .fifo_rd_o(frd), .rd_bytes_o(rbytes));
	// ==========================================================
	// Clock, pulse tallies and a ceiling that catches a hung handshake
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		n_evt += (evt === 1'b1);
		n_ptr += (ptr === 1'b1);
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ==========================================================
	// Bus cycles and comparisons
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until ack is sampled; released one cycle at least
	task xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [9:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask
	task rd_chk(input logic [9:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(q, exp);
	endtask
	task give_verdict;
		$display("cmp_count %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, wdat} = '0;
		sel = 4'hf;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, spare high registers, unmapped word
		rd_chk(USBRX_IDX_LOW1, {24'h0, USBRX_LOW_RST});
		rd_chk(USBRX_IDX_HIGH1, {24'h0, USBRX_HIGH_RST});
		rd_chk(USBRX_IDX_CFG, 32'(USBRX_MAXP_RST));
		wr(USBRX_IDX_HIGH2, 32'ha5);
		rd_chk(USBRX_IDX_HIGH2, 32'ha5);
		wr(USBRX_IDX_HIGH3, 32'h3c);
		rd_chk(USBRX_IDX_HIGH3, 32'h3c);
		wr(10'h200, 32'hff);
		rd_chk(10'h200, 32'h0);
		// Bulk: errors and overrun stay hidden, toggle reset keeps ready
		u_usbrx_usb_model.send(11'h008, 1'b1);
		rd_chk(USBRX_IDX_LOW1, RDY);
		chk(rdy, 32'h1);
		chk(tgl, 32'h1);
		wr(USBRX_IDX_LOW1, TGL | RDY);
		repeat (2) @(posedge clk_i);
		chk(tgl, 32'h0);
		rd_chk(USBRX_IDX_LOW1, RDY);
		u_usbrx_usb_model.send(11'h004, 1'b0);
		u_usbrx_usb_model.send(11'h004, 1'b0);
		rd_chk(USBRX_IDX_LOW1, RDY | FUL);
		chk(full, 32'h1);
		wr(USBRX_IDX_LOW1, 32'h0);
		wr(USBRX_IDX_LOW1, 32'h0);
		rd_chk(USBRX_IDX_LOW1, 32'h0);
		// Stall issue and report, then isochronous where it is ignored
		wr(USBRX_IDX_LOW1, SST);
		repeat (2) @(posedge clk_i);
		chk(stall, 32'h1);
		// Toggle stands at one: one packet stored since the toggle reset, the next dropped
		rd_chk(USBRX_IDX_STAT, (32'h1 << USBRX_ST_STALL_OUT)
			| (32'h1 << USBRX_ST_TOGGLE));
		u_usbrx_usb_model.token();
		rd_chk(USBRX_IDX_LOW1, SST | STD);
		wr(USBRX_IDX_LOW1, STD);
		repeat (2) @(posedge clk_i);
		chk(stall, 32'h0);
		rd_chk(USBRX_IDX_LOW1, STD);
		wr(USBRX_IDX_LOW1, 32'h0);
		wr(USBRX_IDX_CFG, 32'h40 | (32'h1 << USBRX_CFG_ISO));
		wr(USBRX_IDX_LOW1, SST | STD);
		repeat (2) @(posedge clk_i);
		chk(stall, 32'h0);
		u_usbrx_usb_model.token();
		rd_chk(USBRX_IDX_LOW1, SST);
		wr(USBRX_IDX_LOW1, 32'h0);
		// Isochronous: data error, overrun, double flush
		u_usbrx_usb_model.send(11'h004, 1'b1);
		rd_chk(USBRX_IDX_LOW1, RDY | ERR);
		wr(USBRX_IDX_LOW1, 32'h0);
		rd_chk(USBRX_IDX_LOW1, 32'h0);
		repeat (3) u_usbrx_usb_model.send(11'h004, 1'b0);
		rd_chk(USBRX_IDX_LOW1, RDY | FUL | OVR);
		wr(USBRX_IDX_LOW1, RDY | FUL);
		rd_chk(USBRX_IDX_LOW1, RDY | FUL);
		wr(USBRX_IDX_LOW1, FLS | RDY);
		rd_chk(USBRX_IDX_LOW1, RDY);
		wr(USBRX_IDX_LOW1, FLS | RDY);
		rd_chk(USBRX_IDX_LOW1, 32'h0);
		chk(n_ptr, 32'h2);
		// Host role auto-clear, plain and DMA unloads
		for (int i = 0; i < 8; i++) begin
			wr(USBRX_IDX_CFG, 32'(mp[i]) | HOST |
				(dm[i] ? 32'h1 << USBRX_CFG_DMA : 32'h0));
			wr(USBRX_IDX_HIGH1, ACL);
			rd_chk(USBRX_IDX_HIGH1, ACL);
			u_usbrx_usb_model.send(11'(ln[i]), 1'b0);
			u_usbrx_usb_model.unload((ln[i] + 3) / 4);
			repeat (2) @(posedge clk_i);
			rd_chk(USBRX_IDX_LOW1, cl[i] ? 32'h0 : RDY);
			if (!cl[i]) begin
				wr(USBRX_IDX_LOW1, 32'h0);
			end
		end
		rd_chk(USBRX_IDX_LOW1, 32'h0);
		chk(n_evt, 32'hd);
		give_verdict();
	end
endmodule // tb_usbrx_endpoint
